// >>> hw/switch_port_ingress_control.sv
// Per-port enable, speed, flow control, rate limit and ingress filtering
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module switch_port_ingress_control
    import port_ctrl_pkg::*;
#(
    parameter int NP = NUM_PORTS
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [NP-1:0] an_done,
    input wire logic [NP-1:0][1:0] an_speed,
    input wire logic [NP-1:0] an_full_duplex,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic [PORT_W-1:0] rx_port,
    input wire logic [LEN_W-1:0] rx_len,
    input wire logic rx_src_hit,
    input wire logic rx_storm_hit,
    input wire logic [NP-1:0] rx_no_room,
    output logic rx_fwd,
    output logic rx_drop,
    output logic rx_learn,
    input wire logic tx_req,
    input wire logic tx_done,
    input wire logic [PORT_W-1:0] tx_port,
    input wire logic [LEN_W-1:0] tx_len,
    output logic tx_grant,
    output logic tx_refuse,
    output logic [NP-1:0] port_enable,
    output logic [NP-1:0][1:0] port_speed,
    output logic [NP-1:0] port_full_duplex,
    output logic [NP-1:0] pause_req,
    output logic [NP-1:0] backpressure
);
    typedef struct packed {
        cfg_t [NP-1:0] shadow;
        cfg_t [NP-1:0] active;
        logic [NP-1:0] rx_open;
        logic [NP-1:0] tx_open;
        logic [NP-1:0] en;
        logic [NP-1:0] fd;
        logic [NP-1:0][1:0] spd;
        logic [NP-1:0] pause;
        logic [NP-1:0] bp;
        logic rx_fwd;
        logic rx_drop;
        logic rx_learn;
        logic tx_grant;
        logic tx_refuse;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t state_ff;
    state_t nxt_state;
    logic [PORT_W-1:0] wp;
    logic [SEL_W-1:0] sel;
    logic wp_in;
    logic rx_in;
    logic tx_in;
    cfg_t wcfg;
    cfg_t rc;
    logic rx_ok;
    logic tx_ok;
    logic ing_chg;
    logic egr_chg;
    logic rx_bad_inc;
    logic tx_bad_inc;
    logic [NP-1:0][RATE_W-1:0] ing_rates;
    logic [NP-1:0][RATE_W-1:0] egr_rates;
    logic [NP-1:0] ing_over;
    logic [NP-1:0] egr_over;
    logic [CNT_W-1:0] rx_bad_cnt;
    logic [CNT_W-1:0] tx_bad_cnt;

    function automatic logic [RATE_W-1:0] clamp_rate(
        input logic [DATA_W-1:0] v);
        if (v > DATA_W'(RATE_MAX))
            return RATE_MAX;
        return v[RATE_W-1:0];
    endfunction : clamp_rate

    for (genvar g = 0; g < NP; g++)
    begin : g_rates
        assign ing_rates[g] = state_ff.active[g].ing_rate;
        assign egr_rates[g] = state_ff.active[g].egr_rate;
    end

    // Ingress and egress meters keep separate buckets per port
    rate_meter #(.NP(NP)) u_ing_meter (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .rate(ing_rates),
        .charge(ing_chg),
        .charge_port(rx_port),
        .charge_len(rx_len),
        .over(ing_over)
    );

    rate_meter #(.NP(NP)) u_egr_meter (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .rate(egr_rates),
        .charge(egr_chg),
        .charge_port(tx_port),
        .charge_len(tx_len),
        .over(egr_over)
    );

    bad_frame_stats #(.NP(NP), .CW(CNT_W)) u_stats (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .rx_inc(rx_bad_inc),
        .rx_port(rx_port),
        .tx_inc(tx_bad_inc),
        .tx_port(tx_port),
        .rd_port(wp),
        .rx_cnt(rx_bad_cnt),
        .tx_cnt(tx_bad_cnt)
    );

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.rx_fwd = 1'h0;
        nxt_state.rx_drop = 1'h0;
        nxt_state.rx_learn = 1'h0;
        nxt_state.tx_grant = 1'h0;
        nxt_state.tx_refuse = 1'h0;
        nxt_state.rdata = '0;
        wp = reg_addr[ADDR_W-1:SEL_W];
        sel = reg_addr[SEL_W-1:0];
        wp_in = wp < PORT_W'(NP);
        rx_in = rx_port < PORT_W'(NP);
        tx_in = tx_port < PORT_W'(NP);
        wcfg = CFG_RESET;
        rc = CFG_RESET;
        rx_ok = 1'h0;
        tx_ok = 1'h0;
        ing_chg = 1'h0;
        egr_chg = 1'h0;
        rx_bad_inc = 1'h0;
        tx_bad_inc = 1'h0;

        if (reg_wr && wp_in)
        begin
            wcfg = state_ff.shadow[wp];
            case (sel)
                REG_CTRL:
                begin
                    wcfg.enable = reg_wdata[CTL_ENABLE];
                    wcfg.auto_neg = reg_wdata[CTL_AUTO];
                    wcfg.flow_ctrl = reg_wdata[CTL_FLOW];
                    wcfg.secure = reg_wdata[CTL_SECURE];
                    wcfg.broadcast_storm_filter_enable = reg_wdata[CTL_BSF];
                    wcfg.jumbo_en = reg_wdata[CTL_JUMBO];
                    if (!reg_wdata[CTL_AUTO])
                    begin
                        wcfg.speed = reg_wdata[CTL_SPEED +: 2];
                        wcfg.full_duplex = reg_wdata[CTL_DUPLEX];
                    end
                end
                REG_ING_RATE: wcfg.ing_rate = clamp_rate(reg_wdata);
                REG_EGR_RATE: wcfg.egr_rate = clamp_rate(reg_wdata);
                default: ;
            endcase
            nxt_state.shadow[wp] = wcfg;
        end

        if (reg_rd && wp_in)
        begin
            rc = state_ff.shadow[wp];
            case (sel)
                REG_CTRL:
                begin
                    nxt_state.rdata[CTL_ENABLE] = rc.enable;
                    nxt_state.rdata[CTL_AUTO] = rc.auto_neg;
                    nxt_state.rdata[CTL_SPEED +: 2] = rc.speed;
                    nxt_state.rdata[CTL_DUPLEX] = rc.full_duplex;
                    nxt_state.rdata[CTL_FLOW] = rc.flow_ctrl;
                    nxt_state.rdata[CTL_SECURE] = rc.secure;
                    nxt_state.rdata[CTL_BSF] =
                        rc.broadcast_storm_filter_enable;
                    nxt_state.rdata[CTL_JUMBO] = rc.jumbo_en;
                end
                REG_ING_RATE: nxt_state.rdata[RATE_W-1:0] = rc.ing_rate;
                REG_EGR_RATE: nxt_state.rdata[RATE_W-1:0] = rc.egr_rate;
                REG_STATUS:
                begin
                    nxt_state.rdata[STS_AN_DONE] = an_done[wp];
                    nxt_state.rdata[STS_DUPLEX] = state_ff.fd[wp];
                    nxt_state.rdata[STS_SPEED +: 2] = state_ff.spd[wp];
                    nxt_state.rdata[STS_RX_OPEN] = state_ff.rx_open[wp];
                    nxt_state.rdata[STS_TX_OPEN] = state_ff.tx_open[wp];
                    nxt_state.rdata[STS_ING_OVER] = ing_over[wp];
                    nxt_state.rdata[STS_EGR_OVER] = egr_over[wp];
                    nxt_state.rdata[STS_ENABLED] = state_ff.en[wp];
                end
                REG_RX_BAD: nxt_state.rdata[CNT_W-1:0] = rx_bad_cnt;
                REG_TX_BAD: nxt_state.rdata[CNT_W-1:0] = tx_bad_cnt;
                default: ;
            endcase
        end

        for (int p = 0; p < NP; p++)
        begin
            // Hold the old settings while any frame is open on the port
            if (!state_ff.rx_open[p] && !state_ff.tx_open[p])
                nxt_state.active[p] = state_ff.shadow[p];
            nxt_state.spd[p] = state_ff.active[p].auto_neg ?
                an_speed[p] : state_ff.active[p].speed;
            nxt_state.fd[p] = state_ff.active[p].auto_neg ?
                an_full_duplex[p] : state_ff.active[p].full_duplex;
            nxt_state.en[p] = state_ff.active[p].enable &&
                (!state_ff.active[p].auto_neg || an_done[p]);
            nxt_state.pause[p] = nxt_state.en[p] && nxt_state.fd[p] &&
                ((state_ff.active[p].flow_ctrl && rx_no_room[p])
                || ing_over[p]);
            nxt_state.bp[p] = nxt_state.en[p] && !nxt_state.fd[p] &&
                ((state_ff.active[p].flow_ctrl && rx_no_room[p])
                || ing_over[p]);
        end

        // A frame only opens on an enabled port, so disabled ones drop all
        if (rx_sof && rx_in && state_ff.en[rx_port])
            nxt_state.rx_open[rx_port] = 1'h1;
        if (rx_eof)
        begin
            if (rx_in)
            begin
                rc = state_ff.active[rx_port];
                nxt_state.rx_open[rx_port] = 1'h0;
                rx_bad_inc = state_ff.rx_open[rx_port] &&
                    rx_len < MIN_FRAME_OCTETS;
                rx_ok = state_ff.rx_open[rx_port]
                    && !(rc.secure && !rx_src_hit)
                    && !(rx_len > MAX_STD_OCTETS && !rc.jumbo_en)
                    && !(rc.broadcast_storm_filter_enable
                        && rx_storm_hit)
                    && !(rx_len < MIN_FRAME_OCTETS)
                    && !(!rc.flow_ctrl && rx_no_room[rx_port]);
            end
            ing_chg = rx_ok;
            nxt_state.rx_fwd = rx_ok;
            nxt_state.rx_drop = !rx_ok;
            nxt_state.rx_learn = rx_ok && !rc.secure && !rx_src_hit;
        end

        if (tx_done && tx_in)
        begin
            nxt_state.tx_open[tx_port] = 1'h0;
            tx_bad_inc = tx_len < MIN_FRAME_OCTETS;
        end
        if (tx_req)
        begin
            tx_ok = tx_in && state_ff.en[tx_port]
                && !egr_over[tx_port] && !state_ff.tx_open[tx_port];
            egr_chg = tx_ok;
            nxt_state.tx_grant = tx_ok;
            nxt_state.tx_refuse = !tx_ok;
            if (tx_ok)
                nxt_state.tx_open[tx_port] = 1'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= '0;
            state_ff.shadow <= {NP{CFG_RESET}};
            state_ff.active <= {NP{CFG_RESET}};
        end
        else if (ce)
            state_ff <= nxt_state;
    end

    assign reg_rdata = state_ff.rdata;
    assign rx_fwd = state_ff.rx_fwd;
    assign rx_drop = state_ff.rx_drop;
    assign rx_learn = state_ff.rx_learn;
    assign tx_grant = state_ff.tx_grant;
    assign tx_refuse = state_ff.tx_refuse;
    assign port_enable = state_ff.en;
    assign port_speed = state_ff.spd;
    assign port_full_duplex = state_ff.fd;
    assign pause_req = state_ff.pause;
    assign backpressure = state_ff.bp;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    AST_DISABLED_NO_TX: assert property (
        ce && tx_req && tx_in && !state_ff.en[tx_port] |=> tx_refuse)
        else $error("disabled port granted a transmit");
    AST_CLOSED_RX_DROPPED: assert property (
        ce && rx_eof && rx_in && !state_ff.rx_open[rx_port]
        |=> rx_drop && !rx_fwd)
        else $error("frame accepted on a port with no open frame");
    AST_AUTO_SPEED: assert property (
        ce && state_ff.active[0].auto_neg
        |=> port_speed[0] == $past(an_speed[0]))
        else $error("auto port not following negotiated speed");
    AST_FORCED_SPEED: assert property (
        ce && !state_ff.active[0].auto_neg
        |=> port_speed[0] == $past(state_ff.active[0].speed))
        else $error("forced port not at configured speed");
    AST_AUTO_WRITE_IGNORED: assert property (
        ce && reg_wr && reg_addr == {5'h00, REG_CTRL} && reg_wdata[CTL_AUTO]
        |=> state_ff.shadow[0].speed == $past(state_ff.shadow[0].speed))
        else $error("speed written while negotiation automatic");
    AST_PAUSE_ON_FULL: assert property (
        ce && state_ff.active[0].flow_ctrl && rx_no_room[0]
        ##1 ce && state_ff.en[0] && state_ff.fd[0] && rx_no_room[0]
        |=> pause_req[0])
        else $error("no pause request with flow control on");
    AST_DROP_NO_FLOW: assert property (
        ce && rx_eof && rx_in && !state_ff.active[rx_port].flow_ctrl
        && rx_no_room[rx_port] |=> rx_drop)
        else $error("frame kept without room and no flow control");
    AST_RATE_RANGE: assert property (
        state_ff.shadow[0].ing_rate <= RATE_MAX)
        else $error("ingress rate above range");
    AST_EGRESS_LIMIT: assert property (
        ce && tx_req && tx_in && egr_over[tx_port] |=> tx_refuse)
        else $error("transmit granted over egress rate");
    AST_HALF_DUPLEX_BP: assert property (
        ce && ing_over[0] && state_ff.en[0] && !state_ff.fd[0]
        && state_ff.active[0] == $past(state_ff.active[0])
        |=> !pause_req[0])
        else $error("pause sent on a half duplex port");
    AST_SECURE_FILTER: assert property (
        ce && rx_eof && rx_in && state_ff.active[rx_port].secure
        && !rx_src_hit |=> !rx_fwd && !rx_learn)
        else $error("secure port passed unknown source");
    AST_JUMBO_BLOCK: assert property (
        ce && rx_eof && rx_in && rx_len > MAX_STD_OCTETS
        && !state_ff.active[rx_port].jumbo_en |=> rx_drop)
        else $error("jumbo frame forwarded with option off");
    AST_FRAME_FREEZE: assert property (
        ce && state_ff.rx_open[0] |=> $stable(state_ff.active[0]))
        else $error("settings changed inside a frame");

    COV_FORWARD: cover property (ce && rx_eof ##1 rx_fwd && rx_learn);
    COV_TX_REFUSE: cover property (ce && tx_req ##1 tx_refuse);
    COV_PAUSE: cover property (pause_req[0] ##1 !pause_req[0]);
    COV_BACKPRESSURE: cover property (backpressure != '0);
endmodule : switch_port_ingress_control
`default_nettype wire

// >>> hw/port_ctrl_pkg.sv
// Shared constants and types for the switch port control block
package port_ctrl_pkg;
    localparam int NUM_PORTS = 24;
    localparam int PORT_W = 5;
    localparam int RATE_W = 13;
    localparam int LEN_W = 14;
    localparam int CNT_W = 16;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int SEL_W = 3;
    localparam int LVL_W = 40;
    localparam logic [RATE_W-1:0] RATE_MAX = 13'h1f40;
    localparam logic [LEN_W-1:0] MIN_FRAME_OCTETS = 14'h0040;
    localparam logic [LEN_W-1:0] MAX_STD_OCTETS = 14'h05ee;
    localparam longint CLK_HZ = 100000000;
    localparam longint RATE_UNIT_BPS = 128000;
    localparam longint CREDIT_PER_BIT = CLK_HZ / 1000;
    localparam longint REFILL_PER_UNIT = RATE_UNIT_BPS / 1000;
    localparam longint BITS_PER_OCTET = 8;
    localparam longint BURST_BITS = 16384;
    localparam logic [SEL_W-1:0] REG_CTRL = 3'h0;
    localparam logic [SEL_W-1:0] REG_ING_RATE = 3'h1;
    localparam logic [SEL_W-1:0] REG_EGR_RATE = 3'h2;
    localparam logic [SEL_W-1:0] REG_STATUS = 3'h3;
    localparam logic [SEL_W-1:0] REG_RX_BAD = 3'h4;
    localparam logic [SEL_W-1:0] REG_TX_BAD = 3'h5;
    localparam int CTL_ENABLE = 0;
    localparam int CTL_AUTO = 1;
    localparam int CTL_SPEED = 2;
    localparam int CTL_DUPLEX = 4;
    localparam int CTL_FLOW = 5;
    localparam int CTL_SECURE = 6;
    localparam int CTL_BSF = 7;
    localparam int CTL_JUMBO = 8;
    localparam int STS_AN_DONE = 0;
    localparam int STS_DUPLEX = 1;
    localparam int STS_SPEED = 2;
    localparam int STS_RX_OPEN = 4;
    localparam int STS_TX_OPEN = 5;
    localparam int STS_ING_OVER = 6;
    localparam int STS_EGR_OVER = 7;
    localparam int STS_ENABLED = 8;
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;
    typedef struct packed {
        logic enable;
        logic auto_neg;
        logic [1:0] speed;
        logic full_duplex;
        logic flow_ctrl;
        logic secure;
        logic broadcast_storm_filter_enable;
        logic jumbo_en;
        logic [RATE_W-1:0] ing_rate;
        logic [RATE_W-1:0] egr_rate;
    } cfg_t;
    localparam cfg_t CFG_RESET = '{enable: 1'h1, auto_neg: 1'h1,
        speed: SPEED_100, full_duplex: 1'h1, flow_ctrl: 1'h0,
        secure: 1'h0, broadcast_storm_filter_enable: 1'h0,
        jumbo_en: 1'h0, ing_rate: 13'h0000, egr_rate: 13'h0000};
endpackage : port_ctrl_pkg

// >>> hw/rate_meter.sv
// Per-port token bucket meters, one rate setting per port
`timescale 1ns/1ps
`default_nettype none
module rate_meter
    import port_ctrl_pkg::*;
#(
    parameter int NP = NUM_PORTS
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [NP-1:0][RATE_W-1:0] rate,
    input wire logic charge,
    input wire logic [PORT_W-1:0] charge_port,
    input wire logic [LEN_W-1:0] charge_len,
    output logic [NP-1:0] over
);
    localparam logic signed [LVL_W-1:0] CAP =
        LVL_W'(BURST_BITS * CREDIT_PER_BIT);
    localparam logic signed [LVL_W-1:0] REFILL = LVL_W'(REFILL_PER_UNIT);
    localparam logic signed [LVL_W-1:0] OCTET_COST =
        LVL_W'(BITS_PER_OCTET * CREDIT_PER_BIT);

    typedef struct packed {
        logic [NP-1:0][LVL_W-1:0] level;
    } meter_t;

    meter_t state_ff;
    meter_t nxt_state;
    logic [NP-1:0][LVL_W-1:0] nxt_level;

    // Deficit bucket: a frame passes on any non-negative level, then the
    // level may go negative so long frames still pay their full cost
    genvar g;
    for (g = 0; g < NP; g++)
    begin : g_bucket
        logic signed [LVL_W-1:0] lvl;
        logic signed [LVL_W-1:0] sum;
        logic signed [LVL_W-1:0] fill;
        logic signed [LVL_W-1:0] cost;
        assign lvl = $signed(state_ff.level[g]);
        assign sum = lvl + $signed(LVL_W'(rate[g])) * REFILL;
        assign fill = (sum > CAP) ? CAP : sum;
        assign cost = $signed(LVL_W'(charge_len)) * OCTET_COST;
        assign nxt_level[g] = (rate[g] == '0) ? CAP :
            ((charge && charge_port == PORT_W'(g)) ? fill - cost : fill);
        assign over[g] = (rate[g] != '0) && (lvl < 0);
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.level = nxt_level;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            state_ff.level <= {NP{CAP}};
        else if (ce)
            state_ff <= nxt_state;
    end

    AST_ZERO_RATE_OPEN: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ce && rate[0] == '0 |=> !over[0] || rate[0] != '0)
        else $error("meter limits a port with rate zero");
endmodule : rate_meter
`default_nettype wire

// >>> hw/bad_frame_stats.sv
// Per-port receive and transmit bad frame counters
`timescale 1ns/1ps
`default_nettype none
module bad_frame_stats
    import port_ctrl_pkg::*;
#(
    parameter int NP = NUM_PORTS,
    parameter int CW = CNT_W
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic rx_inc,
    input wire logic [PORT_W-1:0] rx_port,
    input wire logic tx_inc,
    input wire logic [PORT_W-1:0] tx_port,
    input wire logic [PORT_W-1:0] rd_port,
    output logic [CW-1:0] rx_cnt,
    output logic [CW-1:0] tx_cnt
);
    typedef struct packed {
        logic [NP-1:0][CW-1:0] rx;
        logic [NP-1:0][CW-1:0] tx;
    } stats_t;

    stats_t state_ff;
    stats_t nxt_state;
    logic [NP-1:0][CW-1:0] rx_next;
    logic [NP-1:0][CW-1:0] tx_next;

    // Saturate rather than wrap so a flood never looks like a clean port
    genvar g;
    for (g = 0; g < NP; g++)
    begin : g_cnt
        assign rx_next[g] = (rx_inc && rx_port == PORT_W'(g)
            && state_ff.rx[g] != '1) ? state_ff.rx[g] + 1'b1 : state_ff.rx[g];
        assign tx_next[g] = (tx_inc && tx_port == PORT_W'(g)
            && state_ff.tx[g] != '1) ? state_ff.tx[g] + 1'b1 : state_ff.tx[g];
    end

    always_comb
    begin
        nxt_state.rx = rx_next;
        nxt_state.tx = tx_next;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            state_ff <= '0;
        else if (ce)
            state_ff <= nxt_state;
    end

    assign rx_cnt = (rd_port < PORT_W'(NP)) ? state_ff.rx[rd_port] : '0;
    assign tx_cnt = (rd_port < PORT_W'(NP)) ? state_ff.tx[rd_port] : '0;

    AST_RX_BAD_COUNT: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ce && rx_inc && rx_port == '0 && state_ff.rx[0] != '1
        |=> state_ff.rx[0] == $past(state_ff.rx[0]) + 1'b1)
        else $error("receive bad frame not counted");
endmodule : bad_frame_stats
`default_nettype wire

// >>> tb/link_partner.sv
// Link partner model: negotiation outcome for every port
`timescale 1ns/1ps
`default_nettype none
module link_partner
    import port_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    output logic [NUM_PORTS-1:0] an_done,
    output logic [NUM_PORTS-1:0][1:0] an_speed,
    output logic [NUM_PORTS-1:0] an_full_duplex
);
    logic [4:0] cnt_ff;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_ff <= 5'h00;
        else
            cnt_ff <= cnt_ff + {4'h0, cnt_ff != 5'h1f};
    end
    // Results read zero until negotiation ends, never stale
    assign an_done = {NUM_PORTS{&cnt_ff}};
    assign an_speed = {NUM_PORTS{&cnt_ff ? SPEED_1000 : 2'h0}};
    assign an_full_duplex = an_done;
endmodule : link_partner
`default_nettype wire

// >>> tb/switch_port_ingress_control_tb.sv
// Self-checking bench for the switch port control block
`timescale 1ns/1ps
`default_nettype none
module switch_port_ingress_control_tb;
    import port_ctrl_pkg::*;
    logic ref_clk = '0, rst_b = '0, ce = '1, reg_wr = '0, reg_rd = '0;
    logic rx_sof = '0, rx_eof = '0, rx_src_hit = '0, rx_storm_hit = '0;
    logic tx_req = '0, tx_done = '0, rx_fwd, rx_drop, rx_learn;
    logic tx_grant, tx_refuse;
    logic [4:0] rx_port = '0, tx_port = '0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, d;
    logic [13:0] rx_len = '0, tx_len = '0;
    logic [23:0] an_done, an_full_duplex, rx_no_room = '0, port_enable;
    logic [23:0] port_full_duplex, pause_req, backpressure;
    logic [23:0][1:0] an_speed, port_speed;
    int n_mismatch = 0, cmp_count = 0, seed = 41, rbad = 0, tbad = 0, c, ln;
    bit h, s, f, eo = 0;
    int ctl[8] = '{'h15, 'h55, 'h95, 'h115, 'h15, 'h25, 'h35, 'h14};
    bit room[8] = '{0, 0, 0, 0, 1, 1, 1, 0};
    int lens[6] = '{40, 63, 64, 1518, 1519, 2000};
    always #5 ref_clk = ~ref_clk;
    link_partner lp (.ref_clk(ref_clk), .rst_b(rst_b), .an_done(an_done),
        .an_speed(an_speed), .an_full_duplex(an_full_duplex));
    switch_port_ingress_control uut (.ref_clk(ref_clk), .rst_b(rst_b),
        .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .an_done(an_done), .an_speed(an_speed),
        .an_full_duplex(an_full_duplex), .rx_sof(rx_sof), .rx_eof(rx_eof),
        .rx_port(rx_port), .rx_len(rx_len), .rx_src_hit(rx_src_hit),
        .rx_storm_hit(rx_storm_hit), .rx_no_room(rx_no_room),
        .rx_fwd(rx_fwd), .rx_drop(rx_drop), .rx_learn(rx_learn),
        .tx_req(tx_req), .tx_done(tx_done), .tx_port(tx_port),
        .tx_len(tx_len), .tx_grant(tx_grant), .tx_refuse(tx_refuse),
        .port_enable(port_enable), .port_speed(port_speed),
        .port_full_duplex(port_full_duplex), .pause_req(pause_req),
        .backpressure(backpressure));
    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= '1;
        @(posedge ref_clk);
        reg_wr <= '0;
    endtask : wr
    task automatic rd(logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= '1;
        @(posedge ref_clk);
        reg_rd <= '0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic frame;
        @(posedge ref_clk);
        rx_sof <= '1;
        @(posedge ref_clk);
        rx_sof <= '0;
        rx_eof <= '1;
        rx_len <= ln[13:0];
        rx_src_hit <= h;
        rx_storm_hit <= s;
        @(posedge ref_clk);
        rx_eof <= '0;
        #1 f = c[0] && !(c[6] && !h) && (ln <= 1518 || c[8]) && ln >= 64
            && !(c[7] && s) && (c[5] || !rx_no_room[0]);
        rbad += c[0] && ln < 64;
        chk("rx_fwd", rx_fwd, f);
        chk("rx_drop", rx_drop, !f);
        chk("rx_learn", rx_learn, f && !h);
    endtask : frame
    task automatic tx(int len);
        bit g;
        g = c[0] && !eo;
        @(posedge ref_clk);
        tx_req <= '1;
        tx_len <= len[13:0];
        @(posedge ref_clk);
        tx_req <= '0;
        tx_done <= g;
        #1 chk("tx_grant", {tx_grant, tx_refuse}, {g, !g});
        @(posedge ref_clk);
        tx_done <= '0;
        tbad += g && len < 64;
    endtask : tx
    task automatic finish_test;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_b <= '1;
        for (int i = 0; i < 99 && port_enable[0] !== 1'h1; i++)
            @(posedge ref_clk);
        wr(8'h00, 32'h3);
        wr(8'h01, 32'h2328);
        wr(8'hc1, 32'h5);
        rd(8'h00);
        chk("ctrl", d, 32'h17);
        chk("speed", port_speed[0], SPEED_1000);
        rd(8'h03);
        chk("status", d, 32'h10b);
        rd(8'h01);
        chk("rate", d, RATE_MAX);
        rd(8'hc1);
        chk("unmapped", d, 32'h0);
        // Write with clock enable low must leave no trace
        ce <= '0;
        wr(8'h02, 32'h5);
        ce <= '1;
        rd(8'h02);
        chk("frozen", d, 32'h0);
        wr(8'h01, 32'h0);
        foreach (ctl[r])
        begin
            c = ctl[r];
            @(posedge ref_clk);
            rx_no_room[0] <= room[r];
            wr(8'h00, c);
            repeat (4) @(posedge ref_clk);
            #1 chk("enable", port_enable[0], c[0]);
            if (c[0])
                chk("mode", {port_full_duplex[0], port_speed[0]}, c[4:2]);
            chk("pause", pause_req[0], c[0] & c[5] & c[4] & room[r]);
            chk("bp", backpressure[0], c[0] & c[5] & !c[4] & room[r]);
            repeat (6)
            begin
                ln = lens[$unsigned($random(seed)) % 6];
                h = $random(seed);
                s = $random(seed);
                frame();
            end
            tx(40);
            tx(100);
            rd(8'h04);
            chk("rx_bad", d, rbad);
            rd(8'h05);
            chk("tx_bad", d, tbad);
        end
        // Lowest egress rate: bucket passes two long frames, refuses the third
        c = 'h15;
        wr(8'h00, c);
        wr(8'h02, 32'h1);
        tx(1500);
        tx(1500);
        eo = 1;
        tx(1500);
        rd(8'h03);
        chk("egr_over", d[STS_EGR_OVER], 1'b1);
        finish_test();
    end
    // Run takes well under a thousand cycles
    initial
    begin
        #100000;
        n_mismatch++;
        finish_test();
    end
endmodule : switch_port_ingress_control_tb
`default_nettype wire
